// ===== core/lstg_map.vh
/*
 constants for the line-scan trigger generator: clock rate, scan limits, fault code, resets.
 assumes inclusion by core/lstg_trigger.v only.
*/
`ifndef LSTG_MAP_VH
`define LSTG_MAP_VH
`define LSTG_CLK_HZ          20000000
`define LSTG_MAX_SCAN_HZ     8500
`define LSTG_MIN_PERIOD_CYC  (`LSTG_CLK_HZ / `LSTG_MAX_SCAN_HZ)
`define LSTG_FAULT_OVERSPEED 8'h0e
`define LSTG_FAULT_NONE      8'h00
`define LSTG_PPL_RESET       16'h0006
`define LSTG_RATE_RESET      14'h03e8
`define LSTG_EXPOSE_CYC      16'h0064
`define LSTG_WIN_LO_RESET    12'h000
`define LSTG_WIN_HI_RESET    12'h0ff
`endif

// ===== core/lstg_trigger.v
/*
 line-scan trigger generator: encoder or timer paced scan triggers, overspeed fault,
 part length in lines, viewing window staging.
 assumes a 20 MHz clock, encoder signal already converted from the differential receiver.
*/
`timescale 1ns/1ps
`include "lstg_map.vh"
module lstg_trigger #(
    parameter CLK_HZ   = `LSTG_CLK_HZ,
    parameter PPL_W    = 16,
    parameter RATE_W   = 14,
    parameter WIN_W    = 12,
    parameter LEN_W    = 16,
    parameter EXPOSE   = `LSTG_EXPOSE_CYC
) (
    // clock and reset
    input  wire              clock,
    input  wire              resetn,
    // encoder receiver
    input  wire              encoderIn,
    // control
    input  wire              encoderMode,
    input  wire              acquire,
    input  wire [PPL_W-1:0]  pulsesPerLine,
    input  wire [RATE_W-1:0] lineRateHz,
    input  wire [WIN_W-1:0]  vertResolution,
    input  wire              partPresent,
    input  wire              faultClear,
    // window staging
    input  wire              winWrite,
    input  wire [WIN_W-1:0]  winLowerIn,
    input  wire [WIN_W-1:0]  winUpperIn,
    input  wire              winAccept,
    // outputs
    output reg               scanTrigger,
    output reg               exposeActive,
    output reg  [7:0]        faultCode,
    output reg  [LEN_W-1:0]  partLength,
    output reg               partLengthValid,
    output reg  [WIN_W-1:0]  winLower,
    output reg  [WIN_W-1:0]  winUpper,
    output reg  [WIN_W-1:0]  pendLower,
    output reg  [WIN_W-1:0]  pendUpper,
    output reg  [WIN_W-1:0]  vertResActive,
    output reg  [PPL_W-1:0]  horizResActive
);
    localparam [31:0] MIN_PER = `LSTG_MIN_PERIOD_CYC;
    localparam [31:0] MAX_HZ  = `LSTG_MAX_SCAN_HZ;

    reg  [2:0]        encSync_r;
    reg               encLevel_r;
    reg  [PPL_W-1:0]  pulseCnt_r;
    reg  [31:0]       phaseAcc_r;
    reg  [31:0]       sinceTrig_r;
    reg               acqPrev_r;
    reg  [15:0]       exposeCnt_r;
    reg               presentPrev_r;
    reg  [LEN_W-1:0]  lineCnt_r;
    wire [PPL_W-1:0]  pplEff;
    wire [31:0]       rateEff;
    wire              encEdge;
    wire              acqStart;
    wire              encTrig;
    wire              timTrig;
    wire              trigNxt;

    // line rate widened to 32 bits and held at the maximum scan rate
    function [31:0] clip_rate;
        input [RATE_W-1:0] rate;
        reg   [31:0]       wide;
        begin
            wide      = {{(32-RATE_W){1'b0}}, rate};
            clip_rate = (wide > MAX_HZ) ? MAX_HZ : wide;
        end
    endfunction

    // pulse count plus one, shared by the trigger test and the counter
    function [PPL_W-1:0] ppl_inc;
        input [PPL_W-1:0] cnt;
        begin
            ppl_inc = cnt + {{(PPL_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // encoder input filtered by three stages, edge counted when stages 2 and 3 agree
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            encSync_r  <= 3'h0;
            encLevel_r <= 1'b0;
        end else begin
            encSync_r <= {encSync_r[1:0], encoderIn};
            if (encSync_r[1] == encSync_r[2])
                encLevel_r <= encSync_r[2];
        end
    end
    assign encEdge  = (encSync_r[1] == encSync_r[2]) && encSync_r[2] && !encLevel_r;
    assign acqStart = acquire && !acqPrev_r;
    assign pplEff   = (pulsesPerLine == {PPL_W{1'b0}}) ? {{(PPL_W-1){1'b0}}, 1'b1}
                                                       : pulsesPerLine;
    assign rateEff  = clip_rate(lineRateHz);
    assign encTrig  = acquire && encoderMode && encEdge &&
                      (ppl_inc(pulseCnt_r) >= pplEff);
    assign timTrig  = acquire && !encoderMode && (rateEff != 32'h0) &&
                      (phaseAcc_r + rateEff >= CLK_HZ);
    assign trigNxt  = encTrig || timTrig;

    // pulse counter and timer phase accumulator
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pulseCnt_r <= {PPL_W{1'b0}};
            phaseAcc_r <= 32'h0;
            acqPrev_r  <= 1'b0;
        end else begin
            acqPrev_r <= acquire;
            if (acqStart || !encoderMode)
                pulseCnt_r <= {PPL_W{1'b0}};
            else if (encTrig)
                pulseCnt_r <= {PPL_W{1'b0}};
            else if (acquire && encEdge)
                pulseCnt_r <= ppl_inc(pulseCnt_r);
            if (acqStart || encoderMode)
                phaseAcc_r <= 32'h0;
            else if (timTrig)
                phaseAcc_r <= phaseAcc_r + rateEff - CLK_HZ;
            else if (acquire)
                phaseAcc_r <= phaseAcc_r + rateEff;
        end
    end

    // trigger, fixed exposure and overspeed fault
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scanTrigger  <= 1'b0;
            exposeActive <= 1'b0;
            exposeCnt_r  <= 16'h0;
            faultCode    <= `LSTG_FAULT_NONE;
        end else begin
            scanTrigger <= trigNxt;
            if (trigNxt) begin
                exposeActive <= 1'b1;
                exposeCnt_r  <= EXPOSE[15:0];
            end else if (exposeCnt_r > 16'h1) begin
                exposeCnt_r <= exposeCnt_r - 16'h1;
            end else begin
                exposeCnt_r  <= 16'h0;
                exposeActive <= 1'b0;
            end
            if (encTrig && !acqStart && sinceTrig_r <= MIN_PER)
                faultCode <= `LSTG_FAULT_OVERSPEED;
            else if (faultClear)
                faultCode <= `LSTG_FAULT_NONE;
        end
    end

    // interval since the last encoder trigger; set to all ones at acquisition start or in timer mode
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sinceTrig_r <= 32'hffffffff;
        end else if (encTrig) begin
            sinceTrig_r <= 32'h1;
        end else if (acqStart || !encoderMode) begin
            sinceTrig_r <= 32'hffffffff;
        end else if (sinceTrig_r != 32'hffffffff) begin
            sinceTrig_r <= sinceTrig_r + 32'h1;
        end
    end

    // part length in scanned lines
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            presentPrev_r   <= 1'b0;
            lineCnt_r       <= {LEN_W{1'b0}};
            partLength      <= {LEN_W{1'b0}};
            partLengthValid <= 1'b0;
        end else begin
            presentPrev_r   <= partPresent;
            partLengthValid <= 1'b0;
            if (partPresent && !presentPrev_r)
                lineCnt_r <= trigNxt ? {{(LEN_W-1){1'b0}}, 1'b1} : {LEN_W{1'b0}};
            else if (partPresent && trigNxt)
                lineCnt_r <= lineCnt_r + {{(LEN_W-1){1'b0}}, 1'b1};
            if (!partPresent && presentPrev_r) begin
                partLength      <= lineCnt_r;
                partLengthValid <= 1'b1;
            end
        end
    end

    // resolution settings and viewing window staging
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pendLower      <= `LSTG_WIN_LO_RESET;
            pendUpper      <= `LSTG_WIN_HI_RESET;
            winLower       <= `LSTG_WIN_LO_RESET;
            winUpper       <= `LSTG_WIN_HI_RESET;
            vertResActive  <= {WIN_W{1'b0}};
            horizResActive <= `LSTG_PPL_RESET;
        end else begin
            vertResActive  <= vertResolution;
            horizResActive <= pplEff;
            if (winWrite && !acquire) begin
                pendLower <= winLowerIn;
                pendUpper <= winUpperIn;
            end
            if (winAccept && !acquire) begin
                winLower <= pendLower;
                winUpper <= pendUpper;
            end
        end
    end
endmodule // lstg_trigger

// ===== tb/line_scan_trigger_generator_bench.sv
/* testbench for lstg_trigger: window staging, encoder and timer pacing, overspeed.
   assumes the encoder model and the bound checker. */
`timescale 1ns/1ps
module line_scan_trigger_generator_bench;
    logic        clock = 0, resetn = 0, acquire = 0, encoderMode = 0, partPresent = 0;
    logic        faultClear = 0, winWrite = 0, winAccept = 0, encRun = 0;
    logic        encoderIn, scanTrigger, exposeActive, partLengthValid;
    logic [15:0] pulsesPerLine = 16'h0006, partLength, horizResActive, expLen[$];
    logic [13:0] lineRateHz = 14'h0000;
    logic [11:0] vertResolution = 12'h000, winLowerIn = 12'h000, winUpperIn = 12'h000;
    logic [11:0] winLower, winUpper, pendLower, pendUpper, vertResActive, lo, hi;
    logic [7:0]  faultCode;
    integer      fails = 0, n_checks = 0, nTrig = 0, nExp = 0, seed = 32'h36d5efca, i;
    lstg_trigger DUT (.clock(clock), .resetn(resetn), .encoderIn(encoderIn),
        .encoderMode(encoderMode), .acquire(acquire), .pulsesPerLine(pulsesPerLine),
        .lineRateHz(lineRateHz), .vertResolution(vertResolution), .partPresent(partPresent),
        .faultClear(faultClear), .winWrite(winWrite), .winLowerIn(winLowerIn),
        .winUpperIn(winUpperIn), .winAccept(winAccept), .scanTrigger(scanTrigger),
        .exposeActive(exposeActive), .faultCode(faultCode), .partLength(partLength),
        .partLengthValid(partLengthValid), .winLower(winLower), .winUpper(winUpper),
        .pendLower(pendLower), .pendUpper(pendUpper), .vertResActive(vertResActive),
        .horizResActive(horizResActive));
    lstg_encoder_model enc (.clock(clock), .run(encRun), .halfPeriod(16'h0190),
        .encoderIn(encoderIn));
    initial forever #25 clock = ~clock;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task give_verdict;
        $display("checks %0d, fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // counts triggers and compares each reported part length with the oldest note
    always @(posedge clock) begin
        if (scanTrigger === 1'b1) nTrig = nTrig + 1;
        if (exposeActive === 1'b1) nExp = nExp + 1;
        if (partLengthValid === 1'b1) chk(partLength, expLen.size() ? expLen.pop_front() : 16'hffff);
    end
    initial begin
        cyc(60000);
        fails++;
        give_verdict;
    end
    initial begin
        cyc(3); resetn <= 1; cyc(2);
        @(negedge clock);
        chk(winUpper, 16'h00ff);
        chk(horizResActive, 16'h0006);
        lo = 12'($random(seed));
        hi = 12'($random(seed));
        @(posedge clock) winLowerIn <= lo; winUpperIn <= hi; winWrite <= 1; vertResolution <= hi;
        @(posedge clock) winLowerIn <= ~lo; acquire <= 1; winAccept <= 1;
        @(posedge clock) winWrite <= 0; winAccept <= 0;
        @(negedge clock);
        chk(pendLower, lo);
        chk(pendUpper, hi);
        chk(winLower, 12'h000);
        chk(vertResActive, hi);
        @(posedge clock) acquire <= 0; winAccept <= 1;
        @(posedge clock) winAccept <= 0;
        @(negedge clock);
        chk(winLower, lo);
        chk(winUpper, hi);
        @(posedge clock) encoderMode <= 1; pulsesPerLine <= 3; acquire <= 1; partPresent <= 1;
        expLen.push_back(16'h0004); nTrig = 0; encRun <= 1;
        nExp = 0;
        cyc(9600); encRun <= 0; cyc(20); partPresent <= 0; cyc(5);
        chk(nTrig, 4);
        chk(16'(nExp), 16'h0190);
        chk(faultCode, 8'h00);
        pulsesPerLine <= 0; nTrig = 0; encRun <= 1; cyc(3300); encRun <= 0; cyc(10);
        chk(nTrig, 4);
        chk(faultCode, 8'h0e);
        faultClear <= 1; cyc(1); faultClear <= 0; cyc(2);
        chk(faultCode, 8'h00);
        encoderMode <= 0; lineRateHz <= 14'h2328;
        for (i = 0; i < 3000 && scanTrigger !== 1'b1; i++) @(negedge clock);
        chk(16'(i < 3000), 16'h0001);
        if (i < 3000) begin
            nTrig = 0;
            cyc(23529);
            @(negedge clock);
            chk(16'(nTrig), 16'h000a);
        end
        give_verdict;
    end
endmodule // line_scan_trigger_generator_bench

// ===== tb/lstg_encoder_model.sv
/* encoder partner: square wave on the receiver line while run is high.
   assumes halfPeriod of a few cycles or more. */
`timescale 1ns/1ps
module lstg_encoder_model (
    // clock
    input  logic        clock,
    // control
    input  logic        run,
    input  logic [15:0] halfPeriod,
    // encoder line
    output logic        encoderIn
);
    logic [15:0] cnt_r = 16'h0000;
    initial encoderIn = 1'b0;
    // pulses only while running, line idles low
    always @(posedge clock) begin
        if (!run) begin
            cnt_r     <= 16'h0000;
            encoderIn <= 1'b0;
        end else if (cnt_r == halfPeriod - 16'h0001) begin
            cnt_r     <= 16'h0000;
            encoderIn <= ~encoderIn;
        end else
            cnt_r <= cnt_r + 16'h0001;
    end
endmodule // lstg_encoder_model

// ===== tb/lstg_trigger_monitor.sv
/* port checker for lstg_trigger.
   assumes binding to every lstg_trigger instance. */
`timescale 1ns/1ps
module lstg_trigger_monitor (
    // clock and reset
    input logic        clock,
    input logic        resetn,
    // inputs
    input logic        acquire,
    input logic        winAccept,
    input logic        partPresent,
    input logic        faultClear,
    input logic [11:0] vertResolution,
    // outputs
    input logic        scanTrigger,
    input logic        exposeActive,
    input logic [7:0]  faultCode,
    input logic        partLengthValid,
    input logic [11:0] winLower,
    input logic [11:0] pendLower,
    input logic [11:0] vertResActive
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    one_pulse_a: assert property (scanTrigger |=> !scanTrigger) else $error("long trigger");
    expose_hold_a: assert property (scanTrigger |=> exposeActive [*8])
        else $error("exposure short");
    idle_quiet_a: assert property (!acquire ##1 !acquire |-> !scanTrigger)
        else $error("trigger while stopped");
    win_frozen_a: assert property (acquire |=> $stable(winLower) && $stable(pendLower))
        else $error("window moved while running");
    accept_copy_a: assert property (winAccept && !acquire |=> winLower == $past(pendLower))
        else $error("accept not applied");
    no_accept_a: assert property (!winAccept |=> $stable(winLower)) else $error("window moved");
    fault_sticky_a: assert property (faultCode == 8'h0e && !faultClear |=> faultCode == 8'h0e)
        else $error("fault lost");
    res_mirror_a: assert property (1'b1 |=> vertResActive == $past(vertResolution))
        else $error("resolution not held");
    len_report_a: assert property ($fell(partPresent) |=> partLengthValid)
        else $error("no part length");
    cover property (scanTrigger && acquire);
    cover property (faultCode == 8'h0e);
    cover property (partLengthValid);
endmodule // lstg_trigger_monitor
bind lstg_trigger lstg_trigger_monitor mon (.clock(clock), .resetn(resetn), .acquire(acquire),
    .winAccept(winAccept), .partPresent(partPresent), .faultClear(faultClear),
    .vertResolution(vertResolution), .scanTrigger(scanTrigger), .exposeActive(exposeActive),
    .faultCode(faultCode), .partLengthValid(partLengthValid), .winLower(winLower),
    .pendLower(pendLower), .vertResActive(vertResActive));
